// [core/serial_baud_rate_generator.sv]
// Serial port rate timer with AXI4-Lite register access.
//
// Notes on behaviour
// - One rate timer, 8 or 16 bits wide, serves async and sync operation.
// - After reset timer is 8-bit; wide-divisor select enables full 16-bit divisor.
// - Timer free-runs; its period comes from the low/high divisor pair.
// - Async multiplier depends on high-speed select and wide-divisor select.
// - Sync mode ignores the high-speed select.
// - Writing either divisor register clears the timer immediately.
// - Async, 8-bit, high-speed clear: rate is clock over 64 times n plus one.
// - Async, 16-bit, high-speed clear: rate is clock over 16 times n plus one.
// - Sync, 8-bit: rate is clock over 4 times n plus one.
// - Divisor n is high register bits 15..8 joined to low register bits 7..0; 8-bit mode uses low register only.
// - Transmit status/control holds sync select bit 4, high-speed bit 2.
// - Rate control holds wide select bit 3, idle flag bit 6; 5,2 read zero.
// - Idle flag reads 0 while receiving, 1 while receiver idle.
`timescale 1ns/100ps
`default_nettype none
`include "brg_defines.svh"

module serial_baud_rate_generator #(
    parameter int DIV_W = 16
) (
    // Clock and reset.
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write address and data.
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    // AXI4-Lite write response.
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output logic [1:0]              s_axi_bresp,
    // AXI4-Lite read.
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire logic [7:0]         s_axi_araddr,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    // Shift logic side.
    input  wire logic               rx_busy,
    output logic                    rate_tick,
    output logic                    sync_mode
);
    import brg_pkg::*;

    // ==========================================================
    // Register bus slave
    brg_pkg::reg8_t baud_control_reg;
    brg_pkg::reg8_t rx_status_reg;
    brg_pkg::reg8_t div_low_reg;
    brg_pkg::reg8_t div_high_reg;
    brg_pkg::reg8_t tx_status_reg;
    logic           rx_idle_reg;
    logic           aw_have_reg;
    logic           w_have_reg;
    logic [7:0]     aw_addr_reg;
    logic [7:0]     w_data_reg;
    logic           w_strb_reg;
    logic           wr_go;
    logic           wr_div;
    logic           wr_hit;
    brg_pkg::reg8_t rd_byte;
    logic           rd_hit;

    assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_hit = aw_addr_reg == `OFS_BAUD_CONTROL || aw_addr_reg == `OFS_RX_STATUS_CTRL
        || aw_addr_reg == `OFS_DIV_LOW || aw_addr_reg == `OFS_DIV_HIGH
        || aw_addr_reg == `OFS_TX_STATUS_CTRL;
    assign wr_div = wr_go && w_strb_reg
        && (aw_addr_reg == `OFS_DIV_LOW || aw_addr_reg == `OFS_DIV_HIGH);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg   <= 1'b0;
            aw_addr_reg   <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg   <= 1'b0;
            w_data_reg   <= 8'h00;
            w_strb_reg   <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data; other lanes are ignored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_control_reg <= `RST_REG8;
            rx_status_reg    <= `RST_REG8;
            div_low_reg      <= `RST_REG8;
            div_high_reg     <= `RST_REG8;
            tx_status_reg    <= `RST_REG8;
        end else if (wr_go && w_strb_reg) begin
            unique case (aw_addr_reg)
                `OFS_BAUD_CONTROL:   baud_control_reg <= w_data_reg & `WMASK_BAUD_CONTROL;
                `OFS_RX_STATUS_CTRL: rx_status_reg <= w_data_reg & `WMASK_RX_STATUS;
                `OFS_DIV_LOW:        div_low_reg <= w_data_reg;
                `OFS_DIV_HIGH:       div_high_reg <= w_data_reg;
                `OFS_TX_STATUS_CTRL: tx_status_reg <= w_data_reg & `WMASK_TX_STATUS;
                default: ;
            endcase
        end
    end

    // Idle flag is low while a reception is in progress.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_idle_reg <= 1'b1;
        end else begin
            rx_idle_reg <= !rx_busy;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            `OFS_BAUD_CONTROL: begin
                rd_byte = baud_control_reg;
                rd_byte[`BIT_RX_IDLE] = rx_idle_reg;
            end
            `OFS_RX_STATUS_CTRL: rd_byte = rx_status_reg;
            `OFS_DIV_LOW:        rd_byte = div_low_reg;
            `OFS_DIV_HIGH:       rd_byte = div_high_reg;
            `OFS_TX_STATUS_CTRL: rd_byte = tx_status_reg;
            default:             rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Rate timer
    logic                wide_sel;
    logic                fast_sel;
    logic                sync_sel;
    brg_pkg::rate_mult_t mult_sel;
    logic [6:0]          mult_val;
    logic [5:0]          pre_max;
    logic [5:0]          pre_reg;
    logic [DIV_W-1:0]    tim_reg;
    logic [DIV_W-1:0]    div_eff;
    logic                pre_wrap;
    logic                tim_wrap;

    assign wide_sel = baud_control_reg[`BIT_WIDE_DIV];
    assign fast_sel = tx_status_reg[`BIT_HIGH_SPEED];
    assign sync_sel = tx_status_reg[`BIT_SYNC_MODE];
    // Narrow mode uses only the low divisor byte.
    assign div_eff = wide_sel ? {div_high_reg, div_low_reg} : {8'h00, div_low_reg};

    always_comb begin
        if (sync_sel) begin
            mult_sel = MULT_X4;
        end else if (wide_sel) begin
            mult_sel = fast_sel ? MULT_X4 : MULT_X16;
        end else begin
            mult_sel = fast_sel ? MULT_X16 : MULT_X64;
        end
    end

    always_comb begin
        unique case (mult_sel)
            MULT_X64: mult_val = `MULT_SLOW;
            MULT_X16: mult_val = `MULT_MID;
            MULT_X4:  mult_val = `MULT_FAST;
            default:  mult_val = `MULT_SLOW;
        endcase
    end

    assign pre_max  = 6'(mult_val - 7'h01);
    assign pre_wrap = pre_reg >= pre_max;
    assign tim_wrap = tim_reg >= div_eff;

    // The prescaler and the timer together give a period of mult times n plus one.
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_div) begin
            pre_reg <= 6'h00;
            tim_reg <= '0;
        end else begin
            pre_reg <= pre_wrap ? 6'h00 : 6'(pre_reg + 6'h01);
            if (pre_wrap) begin
                tim_reg <= tim_wrap ? '0 : tim_reg + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rate_tick <= 1'b0;
            sync_mode <= 1'b0;
        end else begin
            rate_tick <= pre_wrap && tim_wrap && !wr_div;
            sync_mode <= sync_sel;
        end
    end

    // ==========================================================
    // Checks
    logic [23:0] gap_reg;
    logic        clean_reg;
    logic [23:0] period_exp;
    assign period_exp = 24'(mult_val) * (24'(div_eff) + 24'h000001);
    always_ff @(posedge aclk) begin
        if (!aresetn || rate_tick) begin
            gap_reg <= 24'h000000;
        end else begin
            gap_reg <= gap_reg + 24'h000001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || wr_go) begin
            clean_reg <= 1'b0;
        end else if (rate_tick) begin
            clean_reg <= 1'b1;
        end
    end

    property p_period;
        @(posedge aclk) disable iff (!aresetn)
        rate_tick && clean_reg |-> gap_reg == period_exp - 24'h000001;
    endproperty
    a_period: assert property (p_period) else $error("Tick period wrong.");

    property p_restart;
        @(posedge aclk) disable iff (!aresetn)
        wr_div |=> pre_reg == 6'h00 && tim_reg == '0 ##1 !rate_tick;
    endproperty
    a_restart: assert property (p_restart) else $error("Divisor write did not restart.");

    property p_async_slow;
        @(posedge aclk) disable iff (!aresetn)
        !sync_sel && !wide_sel && !fast_sel |-> mult_val == 7'd64;
    endproperty
    a_async_slow: assert property (p_async_slow) else $error("Slow multiplier wrong.");
    property p_async_wide;
        @(posedge aclk) disable iff (!aresetn)
        !sync_sel && wide_sel && !fast_sel |-> mult_val == 7'd16;
    endproperty
    a_async_wide: assert property (p_async_wide) else $error("Wide multiplier wrong.");
    property p_high_speed;
        @(posedge aclk) disable iff (!aresetn)
        !sync_sel && fast_sel |-> mult_val == (wide_sel ? 7'd4 : 7'd16);
    endproperty
    a_high_speed: assert property (p_high_speed) else $error("Fast multiplier wrong.");
    property p_sync;
        @(posedge aclk) disable iff (!aresetn)
        sync_sel |-> mult_val == 7'd4;
    endproperty
    a_sync: assert property (p_sync) else $error("Sync multiplier wrong.");

    // A mode switch may leave the timer above a narrow divisor; one step must bring it back.
    property p_narrow;
        @(posedge aclk) disable iff (!aresetn)
        !wide_sel && pre_wrap |=> tim_reg <= {8'h00, $past(div_low_reg)};
    endproperty
    a_narrow: assert property (p_narrow) else $error("Narrow timer overran.");

    property p_idle;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_BAUD_CONTROL |=>
            s_axi_rdata[`BIT_RX_IDLE] == $past(rx_idle_reg) && !s_axi_rdata[5] && !s_axi_rdata[2];
    endproperty
    a_idle: assert property (p_idle) else $error("Idle flag read wrong.");

    property p_idle_flag;
        @(posedge aclk) disable iff (!aresetn)
        rx_idle_reg == !$past(rx_busy) && baud_control_reg[5] == 1'b0
            && baud_control_reg[2] == 1'b0;
    endproperty
    a_idle_flag: assert property (p_idle_flag) else $error("Idle flag or zero bits wrong.");

    c_tick: cover property (@(posedge aclk) disable iff (!aresetn) rate_tick && clean_reg);
    c_restart: cover property (@(posedge aclk) disable iff (!aresetn) wr_div ##1 !rate_tick);
    c_wide: cover property (@(posedge aclk) disable iff (!aresetn) wide_sel && rate_tick);
    c_sync: cover property (@(posedge aclk) disable iff (!aresetn) sync_sel && rate_tick);
endmodule

`default_nettype wire

// [core/brg_defines.svh]
// Offsets, field positions, reset values and counts of the rate generator.
`ifndef BRG_DEFINES_SVH
`define BRG_DEFINES_SVH

`define OFS_BAUD_CONTROL    8'h00
`define OFS_RX_STATUS_CTRL  8'h04
`define OFS_DIV_LOW         8'h08
`define OFS_DIV_HIGH        8'h0C
`define OFS_TX_STATUS_CTRL  8'h10

`define BIT_RX_IDLE         6
`define BIT_WIDE_DIV        3
`define BIT_SYNC_MODE       4
`define BIT_HIGH_SPEED      2

`define WMASK_BAUD_CONTROL  8'h1B
`define WMASK_RX_STATUS     8'hF8
`define WMASK_TX_STATUS     8'hFD

`define RST_REG8            8'h00

`define MULT_SLOW           7'h40
`define MULT_MID            7'h10
`define MULT_FAST           7'h04

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// [core/brg_pkg.sv]
// Types shared by the rate generator.
package brg_pkg;
    typedef enum logic [1:0] {
        MULT_X64,
        MULT_X16,
        MULT_X4
    } rate_mult_t;
    typedef logic [7:0] reg8_t;
endpackage

// [bench/shift_partner.sv]
// Model of the shift logic that consumes the rate tick and reports reception.
`timescale 1ns/100ps
`default_nettype none

module shift_partner #(
    parameter int FRAME_TICKS = 4
) (
    // Clock and reset.
    input  wire logic aclk,
    input  wire logic aresetn,
    // Rate and frame control.
    input  wire logic rate_tick,
    input  wire logic rx_start,
    output logic      rx_busy
);
    int left;

    // =========================================================
    // Frame timing
    // A frame lasts a fixed number of bit ticks once started.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left <= 0;
        end else if (rx_start && left == 0) begin
            left <= FRAME_TICKS;
        end else if (rate_tick && left != 0) begin
            left <= left - 1;
        end
    end

    assign rx_busy = (left != 0);
endmodule

`default_nettype wire

// [bench/serial_baud_rate_generator_test.sv]
// Self-checking bench for the serial rate generator.
`timescale 1ns/100ps
`default_nettype none
`include "brg_defines.svh"
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin failures++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, s); end end

module serial_baud_rate_generator_test;
    import brg_pkg::*;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic        awvalid = 0;
    logic        wvalid = 0;
    logic        bready = 0;
    logic        arvalid = 0;
    logic        rready = 0;
    logic        rx_start = 0;
    logic [7:0]  awaddr = 0;
    logic [7:0]  araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0]  wstrb = 0;
    logic        awready, wready, bvalid, arready, rvalid, rx_busy, rate_tick, sync_mode;
    logic [1:0]  bresp, rresp, eb;
    logic [31:0] rdata;
    logic [33:0] er;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          tq[$];
    int          failures = 0;
    int          n_compared = 0;
    int          cnt = 0;
    int          c, et, mult, per;
    bit          arm = 0;
    bit          seen = 0;
    reg8_t       lo, hi;
    logic [7:0]  ofs[5] = '{`OFS_BAUD_CONTROL, `OFS_RX_STATUS_CTRL, `OFS_DIV_LOW,
                            `OFS_DIV_HIGH, `OFS_TX_STATUS_CTRL};
    reg8_t       full[5] = '{8'h5B, 8'hF8, 8'hFF, 8'hFF, 8'hFD};

    serial_baud_rate_generator DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .rx_busy(rx_busy),
        .rate_tick(rate_tick), .sync_mode(sync_mode));

    shift_partner FAR (.aclk(aclk), .aresetn(aresetn), .rate_tick(rate_tick),
        .rx_start(rx_start), .rx_busy(rx_busy));

    always #2 aclk = ~aclk;

    // =========================================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input reg8_t d, input logic s, input logic [1:0] r);
        bit ad, wd;
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= {3'h0, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 0;
        wd = 0;
        do begin
            @(posedge aclk);
            if (!ad && awready) begin
                awvalid <= 1'b0;
                ad = 1;
            end
            if (!wd && wready) begin
                wvalid <= 1'b0;
                wd = 1;
            end
        end while (!(ad && wd));
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // =========================================================
    // Output monitor
    always @(posedge aclk) begin
        if (bvalid && bready && bq.size() > 0) begin
            eb = bq.pop_front();
            `CHK("bresp", eb, bresp)
        end
        if (rvalid && rready && rq.size() > 0) begin
            er = rq.pop_front();
            `CHK("rdata", er, {rresp, rdata})
        end
        cnt <= rate_tick ? 1 : cnt + 1;
        seen <= arm ? (seen | rate_tick) : 1'b0;
        if (rate_tick && arm && seen && tq.size() > 0) begin
            et = tq.pop_front();
            `CHK("tick_period", et, cnt)
        end
    end

    // =========================================================
    // Main sequence
    initial begin
        void'($urandom(24));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], {26'h0, (i == 0) ? 8'h40 : 8'h00});
        rd(8'h14, {2'h2, 32'h0});
        wr(8'h14, 8'hFF, 1'b1, 2'h2);
        foreach (ofs[i]) wr(ofs[i], 8'hFF, 1'b1, 2'h0);
        foreach (ofs[i]) rd(ofs[i], {26'h0, full[i]});
        wr(`OFS_DIV_LOW, 8'hAA, 1'b0, 2'h0);
        rd(`OFS_DIV_LOW, {26'h0, 8'hFF});
        wr(`OFS_RX_STATUS_CTRL, 8'h00, 1'b1, 2'h0);
        for (int m = 0; m < 8; m++) begin
            lo = 8'($urandom_range(5));
            hi = 8'($urandom_range(1));
            wr(`OFS_BAUD_CONTROL, {4'h0, m[1], 3'h0}, 1'b1, 2'h0);
            wr(`OFS_TX_STATUS_CTRL, {3'h0, m[2], 1'b0, m[0], 2'h0}, 1'b1, 2'h0);
            @(posedge aclk);
            `CHK("sync_mode", m[2], sync_mode)
            wr(`OFS_DIV_LOW, lo, 1'b1, 2'h0);
            wr(`OFS_DIV_HIGH, hi, 1'b1, 2'h0);
            mult = m[2] ? 4 : m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64);
            per = mult * ((m[1] ? {hi, lo} : lo) + 1);
            repeat (2) tq.push_back(per);
            arm <= 1'b1;
            while (tq.size() > 0) @(posedge aclk);
            arm <= 1'b0;
        end
        wr(`OFS_BAUD_CONTROL, 8'h00, 1'b1, 2'h0);
        wr(`OFS_TX_STATUS_CTRL, 8'h00, 1'b1, 2'h0);
        wr(`OFS_DIV_HIGH, 8'h00, 1'b1, 2'h0);
        wr(`OFS_DIV_LOW, 8'h07, 1'b1, 2'h0);
        repeat (200) @(posedge aclk);
        wr(`OFS_DIV_LOW, 8'h07, 1'b1, 2'h0);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (!rate_tick);
        `CHK("restart", 1'b1, (c >= 509 && c <= 512))
        rx_start <= 1'b1;
        @(posedge aclk);
        rx_start <= 1'b0;
        repeat (2) @(posedge aclk);
        rd(`OFS_BAUD_CONTROL, 34'h000000000);
        while (rx_busy) @(posedge aclk);
        repeat (2) @(posedge aclk);
        rd(`OFS_BAUD_CONTROL, 34'h000000040);
        test_done;
    end

    // =========================================================
    // Watchdog
    initial begin
        repeat (40000) @(posedge aclk);
        failures++;
        test_done;
    end
endmodule

`default_nettype wire
